// ===== rtl/lhpu_limp_unlock.sv
// lhpu_limp_unlock: limp-home password unlock of the engine controller
// assumes APB on pclk, synchronous inputs and an outside keeper
// that echoes lockout_active back on nv_lock_in
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "lhpu_regs.svh"
// How it works
// - limp-home requests count only during a key fault.
// - with no four-digit password stored, limp-home fails.
// - a match with key and password both learnt opens a 30 s window.
// - engine start is allowed only while that window runs.
// - a wrong password blocks limp-home for one hour.
// - the hour cannot be cut and restarts in full at power-up.
// - the password may also come as ignition pulses.
// - an accepted password restarts the 30 s window unless the relock ends in that same cycle.
// - eight seconds after ignition off it locks again.
// - after relocking a new password is needed.
// - with a learnt password a change first needs the old one confirmed.
// - with no password learnt a new one is taken directly.
module lhpu_limp_unlock #(
  parameter int unsigned TICK_CYC   = `LHPU_TICK_CYC,
  parameter int unsigned UNLOCK_MS  = `LHPU_UNLOCK_MS,
  parameter int unsigned RELOCK_MS  = `LHPU_RELOCK_MS,
  parameter int unsigned LOCKOUT_MS = `LHPU_LOCKOUT_MS,
  parameter int unsigned GAP_MS     = `LHPU_GAP_MS
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        key_fault,
  input  wire logic        key_learnt,
  input  wire logic        ign_on,
  input  wire logic        nv_lock_in,
  output logic             start_enable,
  output logic             lockout_active,
  output logic             irq
);
  localparam int unsigned TICK_W = 15;
  localparam int unsigned IW     = `LHPU_IRQ_W;

  lhpu_tmr_if win_if ();
  lhpu_tmr_if off_if ();
  lhpu_tmr_if lock_if ();

  logic [TICK_W-1:0]     pre_reg;
  logic                  tick_reg;
  logic                  ign_q_reg;
  logic                  ign_rise;
  logic                  ign_fall;
  logic                  init_reg;
  logic                  nv_restart;
  logic                  dig_valid;
  logic [3:0]            dig;
  logic [1:0]            dig_cnt_reg;
  logic [11:0]           dig_sr_reg;
  logic                  ign_req;
  lhpu_pkg::lhpu_pwd_t   ign_pwd;
  logic                  setup;
  logic                  access;
  logic                  wr_en;
  logic                  rd_en;
  logic                  hit;
  logic [31:0]           rd_mux;
  logic [31:0]           prdata_reg;
  lhpu_pkg::lhpu_cmd_t   tst_cmd;
  lhpu_pkg::lhpu_pwd_t   entry_reg;
  lhpu_pkg::lhpu_pwd_t   store_reg;
  logic                  learnt_reg;
  logic                  old_ok_reg;
  lhpu_pkg::lhpu_pwd_t   req_pwd;
  logic                  req_limp;
  logic                  match;
  logic                  refuse;
  logic                  grant;
  logic                  wrong;
  logic                  old_bad;
  logic                  teach_ok;
  logic                  teach_bad;
  lhpu_pkg::lhpu_state_t state_reg;
  lhpu_pkg::lhpu_state_t state_next;
  logic [IW-1:0]         irq_reg;
  logic [IW-1:0]         irq_set;
  logic [IW-1:0]         irq_clr;
  logic [IW-1:0]         mask_reg;
  logic [7:0]            stat;

  // shared millisecond prescaler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_reg  <= '0;
      tick_reg <= 1'b0;
    end else if (pre_reg == TICK_W'(TICK_CYC - 1)) begin
      pre_reg  <= '0;
      tick_reg <= 1'b1;
    end else begin
      pre_reg  <= pre_reg + 1'b1;
      tick_reg <= 1'b0;
    end
  end

  // ignition edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ign_q_reg <= 1'b0;
    end else begin
      ign_q_reg <= ign_on;
    end
  end
  assign ign_rise = ign_on && !ign_q_reg;
  assign ign_fall = !ign_on && ign_q_reg;

  lhpu_ign_decode #(
    .GAP_MS (GAP_MS),
    .GAP_W  (11)
  ) u_ign (
    .pclk        (pclk),
    .presetn     (presetn),
    .ign_on      (ign_on),
    .tick        (tick_reg),
    .digit_valid (dig_valid),
    .digit       (dig)
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dig_cnt_reg <= 2'h0;
      dig_sr_reg  <= 12'h000;
    end else if (dig_valid) begin
      dig_cnt_reg <= dig_cnt_reg + 2'h1;
      dig_sr_reg  <= {dig_sr_reg[7:0], dig};
    end
  end
  assign ign_req = dig_valid && dig_cnt_reg == 2'h3;
  assign ign_pwd = {dig_sr_reg, dig};

  // apb: no wait states, read data taken at setup
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr_en  = access && pwrite;
  assign rd_en  = access && !pwrite;
  assign pready = 1'b1;
  assign hit    = paddr == `LHPU_OFS_CMD  || paddr == `LHPU_OFS_PWD  ||
                  paddr == `LHPU_OFS_STAT || paddr == `LHPU_OFS_IRQ  ||
                  paddr == `LHPU_OFS_MASK;
  assign pslverr = access && !hit;

  // status word
  assign stat = {state_reg, old_ok_reg, key_fault, key_learnt,
                 learnt_reg, lock_if.busy, start_enable};

  // write-only words read as zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (paddr == `LHPU_OFS_STAT) begin
      rd_mux = 32'(stat);
    end else if (paddr == `LHPU_OFS_IRQ) begin
      rd_mux = 32'(irq_reg);
    end else if (paddr == `LHPU_OFS_MASK) begin
      rd_mux = 32'(mask_reg);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end
  assign prdata = prdata_reg;

  // password entry word and interrupt mask
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      entry_reg <= 16'h0000;
      mask_reg  <= `LHPU_MASK_RST;
    end else if (wr_en) begin
      if (paddr == `LHPU_OFS_PWD) begin
        entry_reg <= pwdata[`LHPU_PWD_W-1:0];
      end
      if (paddr == `LHPU_OFS_MASK) begin
        mask_reg <= pwdata[IW-1:0];
      end
    end
  end

  // command taken at the access edge
  assign tst_cmd = (wr_en && paddr == `LHPU_OFS_CMD) ?
                   lhpu_pkg::lhpu_cmd_t'(pwdata[`LHPU_CMD_LSB +: 2]) :
                   lhpu_pkg::LHPU_CMD_NONE;

  // tester wins a clash, the ignition entry is lost
  assign req_limp = tst_cmd == lhpu_pkg::LHPU_CMD_LIMP ||
                    (tst_cmd == lhpu_pkg::LHPU_CMD_NONE && ign_req);
  assign req_pwd  = (tst_cmd == lhpu_pkg::LHPU_CMD_NONE) ? ign_pwd :
                    entry_reg;
  assign match = req_pwd == store_reg;
  // refuse without fault, password, learnt key, or in lockout
  assign refuse = !key_fault || !learnt_reg || !key_learnt || lock_if.busy;
  // unlock on a full match, both learnt
  assign grant = req_limp && !refuse && match;
  // a mismatch on a request that is not refused is a wrong password
  assign wrong = req_limp && !refuse && !match;

  // old password check and gated change
  assign old_bad   = tst_cmd == lhpu_pkg::LHPU_CMD_OLD && learnt_reg &&
                     !match;
  // first teach needs no old password
  assign teach_ok  = tst_cmd == lhpu_pkg::LHPU_CMD_TEACH &&
                     (!learnt_reg || old_ok_reg);
  assign teach_bad = tst_cmd == lhpu_pkg::LHPU_CMD_TEACH && !teach_ok;

  // password store, volatile in this block
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      store_reg  <= 16'h0000;
      learnt_reg <= 1'b0;
    end else if (teach_ok) begin
      store_reg  <= entry_reg;
      learnt_reg <= 1'b1;
    end
  end

  // confirmation lasts until the next teach or check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      old_ok_reg <= 1'b0;
    end else if (tst_cmd == lhpu_pkg::LHPU_CMD_OLD) begin
      old_ok_reg <= learnt_reg && match;
    end else if (tst_cmd == lhpu_pkg::LHPU_CMD_TEACH) begin
      old_ok_reg <= 1'b0;
    end
  end

  // saved lockout taken at the first edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_reg <= 1'b0;
    end else begin
      init_reg <= 1'b1;
    end
  end
  assign nv_restart = !init_reg && nv_lock_in;

  // lockout loads the full hour, nothing clears it early
  assign lock_if.load  = wrong || nv_restart;
  assign lock_if.clear = 1'b0;
  assign lock_if.tick  = tick_reg;
  assign lockout_active = lock_if.busy;

  // a grant restarts the window from full unless off_if.done clears it in that same cycle
  assign win_if.load  = grant;
  // relock kills the window so a new password is needed
  assign win_if.clear = off_if.done;
  assign win_if.tick  = tick_reg;

  // relock timer runs while ignition is off
  assign off_if.load  = (state_reg == lhpu_pkg::LHPU_OPEN && ign_fall) ||
                        (grant && !ign_on);
  // a grant out of locked must not be cancelled by the locked clear
  assign off_if.clear = ign_rise || (grant && ign_on) ||
                        (state_reg == lhpu_pkg::LHPU_LOCKED && !grant);
  assign off_if.tick  = tick_reg;

  lhpu_timer #(
    .LEN (UNLOCK_MS),
    .W   (15)
  ) u_win (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (win_if)
  );

  lhpu_timer #(
    .LEN (RELOCK_MS),
    .W   (13)
  ) u_off (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (off_if)
  );

  lhpu_timer #(
    .LEN (LOCKOUT_MS),
    .W   (22)
  ) u_lock (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (lock_if)
  );

  // unlock state: a grant always wins over expiry
  always_comb begin
    state_next = state_reg;
    if (grant) begin
      state_next = ign_on ? lhpu_pkg::LHPU_OPEN : lhpu_pkg::LHPU_OFFWAIT;
    end else begin
      unique case (state_reg)
        lhpu_pkg::LHPU_LOCKED: begin
          state_next = lhpu_pkg::LHPU_LOCKED;
        end
        lhpu_pkg::LHPU_OPEN: begin
          if (win_if.done) begin
            state_next = lhpu_pkg::LHPU_LOCKED;
          end else if (ign_fall) begin
            state_next = lhpu_pkg::LHPU_OFFWAIT;
          end
        end
        lhpu_pkg::LHPU_OFFWAIT: begin
          if (off_if.done || win_if.done) begin
            state_next = lhpu_pkg::LHPU_LOCKED;
          end else if (ign_rise) begin
            state_next = lhpu_pkg::LHPU_OPEN;
          end
        end
        default: begin
          state_next = lhpu_pkg::LHPU_LOCKED;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= lhpu_pkg::LHPU_LOCKED;
    end else begin
      state_reg <= state_next;
    end
  end

  // start only while the window runs
  assign start_enable = win_if.busy &&
                        state_reg != lhpu_pkg::LHPU_LOCKED;

  // events into sticky status bits
  always_comb begin
    irq_set = '0;
    irq_set[`LHPU_IRQ_GRANT]  = grant;
    irq_set[`LHPU_IRQ_WRONG]  = wrong || old_bad;
    irq_set[`LHPU_IRQ_EXPIRE] = win_if.done;
    irq_set[`LHPU_IRQ_RELOCK] = off_if.done;
    irq_set[`LHPU_IRQ_TAUGHT] = teach_ok;
    irq_set[`LHPU_IRQ_REFUSE] = (req_limp && refuse) || teach_bad;
  end

  // clear only what the read returned, so a late event is kept
  assign irq_clr = (rd_en && paddr == `LHPU_OFS_IRQ) ?
                   prdata_reg[IW-1:0] : '0;

  // set wins over the read clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= (irq_reg & ~irq_clr) | irq_set;
    end
  end

  assign irq = |(irq_reg & mask_reg);
endmodule
`default_nettype wire

// ===== rtl/lhpu_regs.svh
// lhpu_regs.svh: register offsets, field positions, reset values, timing
// assumes pclk at 40 ns and one 32-bit APB word per register
`ifndef LHPU_REGS_SVH
`define LHPU_REGS_SVH
// register byte offsets
`define LHPU_OFS_CMD    8'h00
`define LHPU_OFS_PWD    8'h04
`define LHPU_OFS_STAT   8'h08
`define LHPU_OFS_IRQ    8'h0C
`define LHPU_OFS_MASK   8'h10
// command field and password field
`define LHPU_CMD_LSB    0
`define LHPU_PWD_W      16
// status bits
`define LHPU_ST_START   0
`define LHPU_ST_LOCKOUT 1
`define LHPU_ST_PWD_LRN 2
`define LHPU_ST_KEY_LRN 3
`define LHPU_ST_KEY_FLT 4
`define LHPU_ST_OLD_OK  5
`define LHPU_ST_STATE   6
// interrupt bits, shared by status and mask
`define LHPU_IRQ_W      6
`define LHPU_IRQ_GRANT  0
`define LHPU_IRQ_WRONG  1
`define LHPU_IRQ_EXPIRE 2
`define LHPU_IRQ_RELOCK 3
`define LHPU_IRQ_TAUGHT 4
`define LHPU_IRQ_REFUSE 5
`define LHPU_MASK_RST   6'h00
// timing
`define LHPU_CLK_NS     40
`define LHPU_TICK_NS    1000000
`define LHPU_TICK_CYC   (`LHPU_TICK_NS / `LHPU_CLK_NS)
`define LHPU_UNLOCK_S   30
`define LHPU_RELOCK_S   8
`define LHPU_LOCKOUT_H  1
`define LHPU_GAP_MS     2000
`define LHPU_UNLOCK_MS  (`LHPU_UNLOCK_S * 1000)
`define LHPU_RELOCK_MS  (`LHPU_RELOCK_S * 1000)
`define LHPU_LOCKOUT_MS (`LHPU_LOCKOUT_H * 3600000)
`endif

// ===== rtl/lhpu_pkg.sv
// lhpu_pkg: types of the limp-home unlock block
// assumes nothing beyond a SystemVerilog compiler
package lhpu_pkg;
  typedef enum logic [1:0] {
    LHPU_CMD_NONE  = 2'h0,
    LHPU_CMD_LIMP  = 2'h1,
    LHPU_CMD_OLD   = 2'h2,
    LHPU_CMD_TEACH = 2'h3
  } lhpu_cmd_t;
  // gray path locked -> open -> off-wait
  typedef enum logic [1:0] {
    LHPU_LOCKED  = 2'h0,
    LHPU_OPEN    = 2'h1,
    LHPU_OFFWAIT = 2'h3
  } lhpu_state_t;
  typedef logic [15:0] lhpu_pwd_t;
endpackage

// ===== rtl/lhpu_tmr_if.sv
// lhpu_tmr_if: control and status of one millisecond timer
// assumes one controller and one timer share it
`timescale 1ns/10ps
`default_nettype none
interface lhpu_tmr_if;
  logic load;
  logic clear;
  logic tick;
  logic busy;
  logic done;
  modport ctl (output load, output clear, output tick,
               input busy, input done);
  modport tmr (input load, input clear, input tick,
               output busy, output done);
endinterface
`default_nettype wire

// ===== rtl/lhpu_timer.sv
// lhpu_timer: down counter of millisecond ticks with done pulse
// assumes tick is a one-cycle pulse from the block's prescaler
`timescale 1ns/10ps
`default_nettype none
module lhpu_timer #(
  parameter int unsigned LEN = 30000,
  parameter int unsigned W   = 15
) (
  input wire logic pclk,
  input wire logic presetn,
  lhpu_tmr_if.tmr  t
);
  localparam logic [W-1:0] LEN_W = W'(LEN);
  logic [W-1:0] cnt_reg;
  logic         done_reg;

  // clear beats load, load restarts from the full length
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
    end else if (t.clear) begin
      cnt_reg <= '0;
    end else if (t.load) begin
      cnt_reg <= LEN_W;
    end else if (t.tick && cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  // done only on natural expiry, never after clear or reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= t.tick && !t.clear && !t.load && cnt_reg == W'(1);
    end
  end

  assign t.busy = cnt_reg != '0;
  assign t.done = done_reg;
endmodule
`default_nettype wire

// ===== rtl/lhpu_ign_decode.sv
// lhpu_ign_decode: turns ignition on/off pulses into decimal digits
// assumes ign_on is synchronous and tick is a 1 ms pulse
`timescale 1ns/10ps
`default_nettype none
`include "lhpu_regs.svh"
module lhpu_ign_decode #(
  parameter int unsigned GAP_MS = `LHPU_GAP_MS,
  parameter int unsigned GAP_W  = 11
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ign_on,
  input  wire logic       tick,
  output logic            digit_valid,
  output logic [3:0]      digit
);
  logic             ign_q_reg;
  logic [3:0]       pulses_reg;
  logic [GAP_W-1:0] gap_reg;
  logic             rise;
  logic             emit;

  assign rise = ign_on && !ign_q_reg;
  // a digit closes once ignition stays off for the whole gap
  assign emit = tick && !ign_on && gap_reg == GAP_W'(1) && pulses_reg != 4'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ign_q_reg <= 1'b0;
    end else begin
      ign_q_reg <= ign_on;
    end
  end

  // ten pulses stand for the digit zero, more wrap round
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulses_reg <= 4'h0;
    end else if (rise) begin
      pulses_reg <= (pulses_reg == 4'hA) ? 4'h1 : pulses_reg + 4'h1;
    end else if (emit) begin
      pulses_reg <= 4'h0;
    end
  end

  // gap timer reloads while ignition is on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_reg <= '0;
    end else if (ign_on) begin
      gap_reg <= GAP_W'(GAP_MS);
    end else if (tick && gap_reg != '0) begin
      gap_reg <= gap_reg - 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      digit_valid <= 1'b0;
      digit       <= 4'h0;
    end else begin
      digit_valid <= emit;
      if (emit) begin
        digit <= (pulses_reg == 4'hA) ? 4'h0 : pulses_reg;
      end
    end
  end
endmodule
`default_nettype wire

// ===== verif/lhpu_limp_unlock_sva.sv
// lhpu_limp_unlock_sva: port checker of the limp-home unlock block
// assumes one pclk domain and the map of lhpu_regs.svh
`timescale 1ns/10ps
`default_nettype none
`include "lhpu_regs.svh"
module lhpu_limp_unlock_sva #(
  parameter int unsigned TICK_CYC   = 4,
  parameter int unsigned UNLOCK_MS  = 30,
  parameter int unsigned RELOCK_MS  = 8,
  parameter int unsigned LOCKOUT_MS = 50,
  parameter int unsigned GAP_MS     = 3
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic        key_fault,
  input wire logic        key_learnt,
  input wire logic        ign_on,
  input wire logic        nv_lock_in,
  input wire logic        start_enable,
  input wire logic        lockout_active
);
  localparam int RELOCK_CYC = (RELOCK_MS + 1) * TICK_CYC + 2;
  localparam int LOCK_MIN   = (LOCKOUT_MS - 1) * TICK_CYC;
  localparam int OPEN_MAX   = (UNLOCK_MS + GAP_MS + 2) * TICK_CYC;
  localparam int GAP_LO     = (GAP_MS - 1) * TICK_CYC;
  localparam int GAP_HI     = (GAP_MS + 1) * TICK_CYC + 2;
  logic seen_reg;
  logic ign_reg;
  int   lock_reg;
  int   open_reg;
  int   low_reg;
  logic limp_wr;
  logic ign_hit;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // the two grant causes: limp write, closed ignition entry
  assign limp_wr = psel && penable && pwrite && paddr == `LHPU_OFS_CMD
                   && pwdata[1:0] == 2'h1;
  assign ign_hit = low_reg >= GAP_LO && low_reg <= GAP_HI;
  // lengths of lockout, open window and ignition low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_reg <= 1'b0;
      ign_reg  <= 1'b0;
      lock_reg <= 0;
      open_reg <= 0;
      low_reg  <= 0;
    end else begin
      seen_reg <= 1'b1;
      ign_reg  <= ign_on;
      lock_reg <= lockout_active ? lock_reg + 1 : 0;
      open_reg <= (!start_enable || limp_wr || ign_on != ign_reg) ? 0
                  : open_reg + 1;
      low_reg  <= ign_on ? 0 : (low_reg < 1000 ? low_reg + 1 : low_reg);
    end
  end
  sequence s_off_open;
    $fell(ign_on) && start_enable;
  endsequence
  sequence s_closed;
    !start_enable || ign_on;
  endsequence
  property p_relock;
    s_off_open |-> ##[1:RELOCK_CYC] s_closed;
  endproperty
  a_relock: assert property (p_relock)
    else $error("no relock after ignition off");
  property p_window;
    start_enable |-> open_reg <= OPEN_MAX;
  endproperty
  a_window: assert property (p_window)
    else $error("start allowed beyond the window");
  property p_grant_cond;
    $rose(start_enable) |-> $past(key_fault && key_learnt && !lockout_active);
  endproperty
  a_grant_cond: assert property (p_grant_cond)
    else $error("grant while refused");
  property p_grant_cause;
    $rose(start_enable) |-> $past(limp_wr || ign_hit);
  endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("start without fresh password");
  property p_lock_min;
    $fell(lockout_active) |-> lock_reg >= LOCK_MIN;
  endproperty
  a_lock_min: assert property (p_lock_min)
    else $error("lockout ended early");
  property p_nv_lock;
    (!seen_reg && nv_lock_in) |=> lockout_active;
  endproperty
  a_nv_lock: assert property (p_nv_lock)
    else $error("saved lockout not restarted");
  property p_lock_cause;
    $rose(lockout_active) |-> $past(limp_wr || !seen_reg || ign_hit);
  endproperty
  a_lock_cause: assert property (p_lock_cause)
    else $error("lockout without password check");
  property p_unmapped;
    psel && penable && paddr > `LHPU_OFS_MASK |-> pslverr;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access not flagged");
endmodule
bind lhpu_limp_unlock lhpu_limp_unlock_sva #(.TICK_CYC(TICK_CYC),
  .UNLOCK_MS(UNLOCK_MS), .RELOCK_MS(RELOCK_MS), .LOCKOUT_MS(LOCKOUT_MS),
  .GAP_MS(GAP_MS)) u_sva (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pslverr, .key_fault, .key_learnt, .ign_on,
  .nv_lock_in, .start_enable, .lockout_active);
`default_nettype wire

// ===== verif/lhpu_ign_model.sv
// lhpu_ign_model: driver's ignition switch keying in a coded password
// assumes a tick of TICK_CYC cycles; the switch is always driven
`timescale 1ns/10ps
`default_nettype none
module lhpu_ign_model #(
  parameter int unsigned TICK_CYC = 4,
  parameter int unsigned GAP_MS   = 3
) (
  input  wire logic pclk,
  output var logic  ign_on
);
  initial ign_on = 1'b0;
  // leave the switch at one position
  task automatic level(input logic v);
    @(posedge pclk);
    ign_on <= v;
  endtask
  // coded ignition entry
  // ten pulses stand for zero; gaps close all digits but the last
  task automatic send(input logic [15:0] pwd);
    int n;
    for (int d = 3; d >= 0; d--) begin
      n = pwd[4*d +: 4] == 4'h0 ? 10 : int'(pwd[4*d +: 4]);
      repeat (n) begin
        @(posedge pclk);
        ign_on <= 1'b1;
        repeat (2) @(posedge pclk);
        ign_on <= 1'b0;
        @(posedge pclk);
      end
      if (d > 0) repeat ((GAP_MS + 1) * TICK_CYC + 2) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

// ===== verif/lhpu_limp_unlock_test.sv
// lhpu_limp_unlock_test: self-checking bench of the limp-home unlock
// assumes shortened timers so that an hour fits in a few hundred cycles
`timescale 1ns/10ps
`default_nettype none
`include "lhpu_regs.svh"
module lhpu_limp_unlock_test;
  localparam int TK = 4, UN = 30, RL = 8, LK = 50, GP = 3;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0, key_fault = 1'b1, key_learnt = 1'b1;
  logic        nv_lock_in = 1'b0, err, ign_on, pready, pslverr, irq;
  logic        start_enable, lockout_active;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [5:0]  mask_v = 6'h00;
  logic [15:0] pw, w;
  int          fail_count = 0, check_count = 0, n;
  always #20 pclk = ~pclk;
  lhpu_limp_unlock #(.TICK_CYC(TK), .UNLOCK_MS(UN), .RELOCK_MS(RL),
    .LOCKOUT_MS(LK), .GAP_MS(GP)) u_dut (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .key_fault,
    .key_learnt, .ign_on, .nv_lock_in, .start_enable, .lockout_active, .irq);
  lhpu_ign_model #(.TICK_CYC(TK), .GAP_MS(GP)) u_ign (.pclk, .ign_on);
  task automatic check(input string s, input logic [31:0] e, g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", s, e, g);
    end
  endtask
  task automatic is1(input string s, input logic b);
    check(s, 32'h1, {31'h0, b});
  endtask
  // one transfer, then a spare edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic cmd(input lhpu_pkg::lhpu_cmd_t c, logic [15:0] p);
    apb(1'b1, `LHPU_OFS_PWD, {16'h0, p});
    apb(1'b1, `LHPU_OFS_CMD, {30'h0, c});
  endtask
  // pin, then the clearing read
  task automatic irq_chk(input logic [5:0] e);
    @(posedge pclk);
    check("irq pin", {31'h0, |(e & mask_v)}, {31'h0, irq});
    apb(1'b0, `LHPU_OFS_IRQ, 32'h0);
    check("irq status", {26'h0, e}, q);
  endtask
  function automatic logic [31:0] exp_stat(input logic st, lk, ln, ok);
    return {26'h0, ok, key_fault, key_learnt, ln, lk, st};
  endfunction
  task automatic stat_chk(input logic st, lk, ln, ok);
    apb(1'b0, `LHPU_OFS_STAT, 32'h0);
    check("status", exp_stat(st, lk, ln, ok), {26'h0, q[5:0]});
  endtask
  // cycles a flag stays high, bounded against a hang
  task automatic hold_len(input bit lk, output int c);
    c = 0;
    while ((lk ? lockout_active : start_enable) === 1'b1 && c < 1000) begin
      @(posedge pclk);
      c++;
    end
  endtask
  function automatic logic [15:0] rand_pwd();
    logic [15:0] p;
    for (int i = 0; i < 4; i++) p[4*i +: 4] = 4'($urandom % 10);
    return p;
  endfunction
  // one digit moved on by one
  function automatic logic [15:0] bad_pwd(input logic [15:0] p, int k);
    p[4*k +: 4] = 4'((int'(p[4*k +: 4]) + 1) % 10);
    return p;
  endfunction
  task automatic close_out();
    $display("checks %0d, mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  // the whole run needs under 2000 cycles
  initial begin
    repeat (8000) @(posedge pclk);
    fail_count++;
    close_out();
  end
  initial begin
    void'($urandom(39863));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `LHPU_OFS_MASK, 32'h0);
    check("mask reset", 32'h0, q);
    apb(1'b0, 8'h14, 32'h0);
    is1("unmapped error", err);
    pw = rand_pwd();
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    is1("masked irq", !irq);
    apb(1'b1, `LHPU_OFS_MASK, 32'h3F);
    mask_v = 6'h3F;
    irq_chk(6'h20);
    stat_chk(1'b0, 1'b0, 1'b0, 1'b0);
    is1("irq cleared", !irq);
    cmd(lhpu_pkg::LHPU_CMD_TEACH, pw);
    irq_chk(6'h10);
    w = rand_pwd();
    cmd(lhpu_pkg::LHPU_CMD_TEACH, w);
    irq_chk(6'h20);
    repeat (GP * TK) @(posedge pclk);
    cmd(lhpu_pkg::LHPU_CMD_OLD, bad_pwd(pw, 0));
    irq_chk(6'h02);
    cmd(lhpu_pkg::LHPU_CMD_OLD, pw);
    stat_chk(1'b0, 1'b0, 1'b1, 1'b1);
    cmd(lhpu_pkg::LHPU_CMD_TEACH, w);
    irq_chk(6'h10);
    pw = w;
    u_ign.send(pw);
    n = 0;
    while (start_enable !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    is1("ignition grant", start_enable);
    hold_len(1'b0, n);
    is1("relock span", n <= (RL + 1) * TK + 2);
    irq_chk(6'h09);
    stat_chk(1'b0, 1'b0, 1'b1, 1'b0);
    u_ign.level(1'b1);
    key_fault <= 1'b0;
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    irq_chk(6'h20);
    key_fault  <= 1'b1;
    key_learnt <= 1'b0;
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    irq_chk(6'h20);
    key_learnt <= 1'b1;
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    stat_chk(1'b1, 1'b0, 1'b1, 1'b0);
    repeat (10 * TK) @(posedge pclk);
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    hold_len(1'b0, n);
    is1("window span", n >= (UN - 1) * TK - 2 && n <= UN * TK + 2);
    irq_chk(6'h05);
    stat_chk(1'b0, 1'b0, 1'b1, 1'b0);
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    u_ign.level(1'b0);
    hold_len(1'b0, n);
    is1("ign off span", n <= (RL + 1) * TK + 2);
    irq_chk(6'h09);
    for (int k = 0; k < 4; k++) begin
      cmd(lhpu_pkg::LHPU_CMD_LIMP, bad_pwd(pw, k));
      irq_chk(6'h02);
      stat_chk(1'b0, 1'b1, 1'b1, 1'b0);
      cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
      irq_chk(6'h20);
      hold_len(1'b1, n);
      is1("lockout span", n >= (LK - 1) * TK - 40 && n <= LK * TK);
    end
    cmd(lhpu_pkg::LHPU_CMD_LIMP, pw);
    stat_chk(1'b1, 1'b0, 1'b1, 1'b0);
    nv_lock_in <= 1'b1;
    presetn    <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    hold_len(1'b1, n);
    is1("restored lockout", n >= (LK - 1) * TK - 2);
    close_out();
  end
endmodule
`default_nettype wire
